// ### core/plld_defs.svh
// constants of the lock detector: register offsets, field positions, reset values, counts
// assumes inclusion by bare name from the package and the top module
`ifndef PLLD_DEFS_SVH
`define PLLD_DEFS_SVH
// ----------------------------------------------------------------
// register map (byte address = 4 * index)
// ----------------------------------------------------------------
`define PLLD_IDX_CFG 8'h07
`define PLLD_ADDR_CFG 8'h1C
`define PLLD_ADDR_STATE 8'h20
`define PLLD_ADDR_IRQ_STAT 8'h24
`define PLLD_ADDR_IRQ_MASK 8'h28
`define PLLD_ADDR_HITS 8'h2C
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PLLD_CFG_RESET 24'h00014D
`define PLLD_CFG_WMASK 24'h002FCF
`define PLLD_CFG_TGT_LSB 0
`define PLLD_CFG_EN_BIT 3
`define PLLD_CFG_DIG_BIT 6
`define PLLD_CFG_WIN_LSB 7
`define PLLD_CFG_RATE_LSB 10
`define PLLD_CFG_RELOCK_BIT 13
`define PLLD_IRQ_BITS 3
`define PLLD_IRQ_GAINED 0
`define PLLD_IRQ_LOST 1
`define PLLD_IRQ_RELOCK 2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PLLD_CLK_NS 100
`define PLLD_ONESHOT_NS 10
// one-shot time rounds down, but never below one cycle
`define PLLD_ONESHOT_CYC ((`PLLD_ONESHOT_NS / `PLLD_CLK_NS) < 1 ? 1 : (`PLLD_ONESHOT_NS / `PLLD_CLK_NS))
`endif

// ### core/plld_pkg.sv
// types of the lock detector
// assumes plld_defs.svh on the include path
`include "plld_defs.svh"
package plld_pkg;
   // ----------------------------------------------------------------
   // configuration word, same layout as the register
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [9:0] rsvd_hi;
      logic relock_once;
      logic rsvd12;
      logic [1:0] timer_rate;
      logic [2:0] win_code;
      logic win_digital;
      logic [1:0] rsvd54;
      logic det_enable;
      logic [2:0] lock_hit_count_target;
   } plld_cfg_t;
   typedef struct packed {
      logic relock;
      logic lost;
      logic gained;
   } plld_evt_t;
   typedef enum logic [1:0] {
      PLLD_ST_OFF,
      PLLD_ST_COUNT,
      PLLD_ST_LOCKED
   } plld_state_t;
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } plld_avs_req_t;
endpackage

// ### core/plld_top.sv
// lock detector of a fractional-n synthesizer with an avalon-mm register slave
// assumes reference and divided oscillator edges arrive as asynchronous pins
//
// What this block does
// - count code 0..7 selects 5,32,96,256,512,2048,8192,65535 consecutive hits.
// - lock is declared only after the selected number of consecutive in-window hits.
// - config bit 3 enables the detector; cleared means detector unused.
// - config bit 6 picks digital timer window or analog one-shot; the 10 ns one-shot is held for one 100 ns clock.
// - bits 9:7 set digital window: half cycle, then 1 to 64 cycles.
// - bits 11:10 set timer rate, 00 fastest, 11 slowest.
// - bit 13 set: one automatic relock attempt after a lock failure, armed again only by the next gained lock.
// - configuration register resets to 0x00014D.
`timescale 1ns/10ps
`include "plld_defs.svh"
module plld_top (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ref_edge,
   input wire logic i_div_edge,
   input wire plld_pkg::plld_avs_req_t i_avs,
   output logic o_avs_waitrequest,
   output logic [31:0] o_avs_readdata,
   output logic o_lock_detect,
   output logic o_relock_req,
   output logic o_irq
);
   import plld_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [1:0] ref_sync_r;
   logic [1:0] div_sync_r;
   logic ref_prev_r;
   logic div_prev_r;
   logic ref_rise;
   logic div_rise;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ref_sync_r <= 2'h0;
         div_sync_r <= 2'h0;
         ref_prev_r <= 1'b0;
         div_prev_r <= 1'b0;
      end else begin
         ref_sync_r <= {ref_sync_r[0], i_ref_edge};
         div_sync_r <= {div_sync_r[0], i_div_edge};
         ref_prev_r <= ref_sync_r[1];
         div_prev_r <= div_sync_r[1];
      end
   end

   assign ref_rise = ref_sync_r[1] & ~ref_prev_r;
   assign div_rise = div_sync_r[1] & ~div_prev_r;

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   plld_cfg_t cfg_r;
   logic [`PLLD_IRQ_BITS-1:0] irq_stat_r;
   logic [`PLLD_IRQ_BITS-1:0] irq_mask_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [31:0] be_mask;
   logic wr_take;
   logic [16:0] hits_r;
   plld_state_t state_r;
   plld_evt_t evt;

   assign be_mask = {{8{i_avs.byteenable[3]}}, {8{i_avs.byteenable[2]}},
                     {8{i_avs.byteenable[1]}}, {8{i_avs.byteenable[0]}}};
   // a write is taken at the edge where waitrequest is seen low; a read is sampled while it is still high
   assign wr_take = i_avs.write & ~wait_r;

   // one wait cycle per access gives the read mux a full cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~((i_avs.read | i_avs.write) & wait_r);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_avs.read && wait_r) begin
         case (i_avs.address)
            `PLLD_ADDR_CFG: rdata_r <= {8'h00, cfg_r};
            `PLLD_ADDR_STATE: rdata_r <= {29'h0000_0000, state_r == PLLD_ST_LOCKED, state_r};
            `PLLD_ADDR_IRQ_STAT: rdata_r <= {29'h0000_0000, irq_stat_r};
            `PLLD_ADDR_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask_r};
            `PLLD_ADDR_HITS: rdata_r <= {15'h0000, hits_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // reserved bits are not stored and read back as zero
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_r <= `PLLD_CFG_RESET;
      end else if (wr_take && i_avs.address == `PLLD_ADDR_CFG) begin
         cfg_r <= (cfg_r & ~(be_mask[23:0] & `PLLD_CFG_WMASK))
                  | (i_avs.writedata[23:0] & be_mask[23:0] & `PLLD_CFG_WMASK);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_mask_r <= 3'h0;
      end else if (wr_take && i_avs.address == `PLLD_ADDR_IRQ_MASK && i_avs.byteenable[0]) begin
         irq_mask_r <= i_avs.writedata[`PLLD_IRQ_BITS-1:0];
      end
   end

   // write one to clear; an event in the same cycle wins over the clear
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_stat_r <= 3'h0;
      end else begin
         if (wr_take && i_avs.address == `PLLD_ADDR_IRQ_STAT && i_avs.byteenable[0]) begin
            irq_stat_r <= (irq_stat_r & ~i_avs.writedata[`PLLD_IRQ_BITS-1:0]) | evt;
         end else begin
            irq_stat_r <= irq_stat_r | evt;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign o_avs_waitrequest = wait_r;
   assign o_avs_readdata = rdata_r;

   // ----------------------------------------------------------------
   // window timer
   // ----------------------------------------------------------------
   // digital window counts half-ticks; a half-tick lasts 2**rate clocks
   logic [2:0] pre_r;
   logic [2:0] pre_last;
   logic half_tick;
   logic [7:0] win_left_r;
   logic [7:0] win_len;
   logic win_open;
   logic win_hit_r;
   logic hit;
   logic miss;

   assign pre_last = 3'((4'h1 << cfg_r.timer_rate) - 4'h1);
   assign half_tick = cfg_r.win_digital ? (pre_r >= pre_last) : 1'b1; // a slower-to-faster rate change must not stall
   assign win_len = cfg_r.win_digital ? (8'h01 << cfg_r.win_code)
                                      : 8'(`PLLD_ONESHOT_CYC);
   assign win_open = win_left_r != 8'h00;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pre_r <= 3'h0;
      end else if (ref_rise || half_tick) begin
         pre_r <= 3'h0;
      end else begin
         pre_r <= pre_r + 3'h1;
      end
   end

   // window opens on the reference edge; the edge cycle itself counts as inside
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         win_left_r <= 8'h00;
      end else if (ref_rise) begin
         win_left_r <= win_len;
      end else if (win_open && half_tick) begin
         win_left_r <= win_left_r - 8'h01;
      end
   end

   assign hit = div_rise & (ref_rise | win_open) & cfg_r.det_enable;
   // a divided edge outside the window, or a window that closes empty, is a miss
   assign miss = cfg_r.det_enable & ((div_rise & ~(ref_rise | win_open))
                 | (win_left_r == 8'h01 && half_tick && !win_hit_r && !ref_rise && !div_rise));

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         win_hit_r <= 1'b0;
      end else if (ref_rise) begin
         win_hit_r <= hit;
      end else if (hit) begin
         win_hit_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // hit counter and lock state
   // ----------------------------------------------------------------
   logic [16:0] target;

   always_comb begin
      case (cfg_r.lock_hit_count_target)
         3'h0: target = 17'd5;
         3'h1: target = 17'd32;
         3'h2: target = 17'd96;
         3'h3: target = 17'd256;
         3'h4: target = 17'd512;
         3'h5: target = 17'd2048;
         3'h6: target = 17'd8192;
         default: target = 17'd65535;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hits_r <= 17'h0_0000;
      end else if (!cfg_r.det_enable || miss) begin
         hits_r <= 17'h0_0000;
      end else if (hit && hits_r < target) begin
         hits_r <= hits_r + 17'h0_0001;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= PLLD_ST_OFF;
      end else begin
         case (state_r)
            PLLD_ST_OFF: begin
               if (cfg_r.det_enable) begin
                  state_r <= PLLD_ST_COUNT;
               end
            end
            PLLD_ST_COUNT: begin
               if (!cfg_r.det_enable) begin
                  state_r <= PLLD_ST_OFF;
               end else if (hit && !miss && hits_r + 17'h0_0001 >= target) begin
                  state_r <= PLLD_ST_LOCKED;
               end
            end
            PLLD_ST_LOCKED: begin
               if (!cfg_r.det_enable) begin
                  state_r <= PLLD_ST_OFF;
               end else if (miss) begin
                  state_r <= PLLD_ST_COUNT;
               end
            end
            default: state_r <= PLLD_ST_OFF;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_lock_detect <= 1'b0;
      end else begin
         o_lock_detect <= (state_r == PLLD_ST_LOCKED) && cfg_r.det_enable && !miss;
      end
   end

   // ----------------------------------------------------------------
   // single relock attempt
   // ----------------------------------------------------------------
   // armed by each gained lock, so a failed attempt is never repeated
   logic relock_used_r;
   logic lost_now;

   assign lost_now = (state_r == PLLD_ST_LOCKED) && (miss || !cfg_r.det_enable);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         relock_used_r <= 1'b0;
         o_relock_req <= 1'b0;
      end else begin
         o_relock_req <= lost_now && cfg_r.relock_once && !relock_used_r;
         if (lost_now && cfg_r.relock_once) begin
            relock_used_r <= 1'b1;
         end else if (evt.gained) begin
            relock_used_r <= 1'b0;
         end
      end
   end

   assign evt.gained = (state_r == PLLD_ST_COUNT) && cfg_r.det_enable && hit && !miss
                       && hits_r + 17'h0_0001 >= target;
   assign evt.lost = lost_now;
   assign evt.relock = lost_now && cfg_r.relock_once && !relock_used_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_reset_cfg;
      @(posedge i_clk) $rose(i_arst_n) |-> cfg_r == `PLLD_CFG_RESET;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config not at reset value");

   property p_lock_needs_target;
      @(posedge i_clk) disable iff (!i_arst_n)
         $rose(o_lock_detect) |-> $past(hits_r) + 17'h0_0001 >= $past(target, 2) || $past(hits_r) >= $past(target);
   endproperty
   a_lock_needs_target: assert property (p_lock_needs_target) else $error("lock before target");

   property p_target_min;
      @(posedge i_clk) disable iff (!i_arst_n)
         cfg_r.lock_hit_count_target == 3'h0 |-> target == 17'd5;
   endproperty
   a_target_min: assert property (p_target_min) else $error("code 0 target wrong");

   property p_target_max;
      @(posedge i_clk) disable iff (!i_arst_n)
         cfg_r.lock_hit_count_target == 3'h7 |-> target == 17'd65535 && hits_r <= 17'd65535;
   endproperty
   a_target_max: assert property (p_target_max) else $error("code 7 target wrong");

   property p_disabled_no_lock;
      @(posedge i_clk) disable iff (!i_arst_n)
         !cfg_r.det_enable |=> !o_lock_detect && hits_r == 17'h0_0000;
   endproperty
   a_disabled_no_lock: assert property (p_disabled_no_lock) else $error("lock while disabled");

   property p_miss_clears;
      @(posedge i_clk) disable iff (!i_arst_n)
         miss |=> hits_r == 17'h0_0000 && !o_lock_detect;
   endproperty
   a_miss_clears: assert property (p_miss_clears) else $error("miss did not clear");

   property p_oneshot_window;
      @(posedge i_clk) disable iff (!i_arst_n)
         ref_rise && !cfg_r.win_digital |=> win_left_r == 8'h01 ##1 win_left_r == 8'h00 || $past(ref_rise);
   endproperty
   a_oneshot_window: assert property (p_oneshot_window) else $error("one-shot window length");

   property p_digital_window;
      @(posedge i_clk) disable iff (!i_arst_n)
         ref_rise && cfg_r.win_digital |=> win_left_r == (8'h01 << cfg_r.win_code);
   endproperty
   a_digital_window: assert property (p_digital_window) else $error("digital window length");

   property p_rate_fastest;
      @(posedge i_clk) disable iff (!i_arst_n)
         cfg_r.win_digital && cfg_r.timer_rate == 2'h0 |-> half_tick;
   endproperty
   a_rate_fastest: assert property (p_rate_fastest) else $error("fastest rate not every cycle");

   property p_relock_once;
      @(posedge i_clk) disable iff (!i_arst_n)
         o_relock_req |=> !o_relock_req [*8];
   endproperty
   a_relock_once: assert property (p_relock_once) else $error("second relock attempt");

   property p_relock_needs_enable;
      @(posedge i_clk) disable iff (!i_arst_n)
         o_relock_req |-> $past(cfg_r.relock_once) && $past(lost_now);
   endproperty
   a_relock_needs_enable: assert property (p_relock_needs_enable) else $error("relock without cause");

   property p_ack_one_wait;
      @(posedge i_clk) disable iff (!i_arst_n)
         (i_avs.read || i_avs.write) && wait_r |=> !o_avs_waitrequest;
   endproperty
   a_ack_one_wait: assert property (p_ack_one_wait) else $error("bus answer late");

   c_lock: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_lock_detect));
   c_loss: cover property (@(posedge i_clk) disable iff (!i_arst_n) $fell(o_lock_detect) && cfg_r.det_enable);
   c_relock: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_relock_req);
   c_irq: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_irq));
endmodule

// ### sim/plld_edge_model.sv
// edge source standing in for the phase detector path: reference and divided oscillator edges
// assumes the detector's clock; both pins stay low between bursts, as the real path is quiet then
`timescale 1ns/10ps
module plld_edge_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_go,
   input wire logic [15:0] i_pairs,
   input wire logic [15:0] i_offset,
   input wire logic [15:0] i_period,
   output logic o_ref_edge,
   output logic o_div_edge,
   output logic [15:0] o_sent
);
   logic [15:0] cnt_r;
   logic run;
   assign run = i_go && (o_sent != i_pairs);
   // pulses last two cycles so the detector's two-flop sync cannot drop one
   assign o_ref_edge = run && (cnt_r < 16'h0002);
   // an offset beyond the window is the commanded late edge
   assign o_div_edge = run && (cnt_r >= i_offset) && (cnt_r < i_offset + 16'h0002);
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= 16'h0000;
         o_sent <= 16'h0000;
      end else if (!run) begin
         cnt_r <= 16'h0000;
         if (!i_go) o_sent <= 16'h0000;
      end else if (cnt_r == i_period - 16'h0001) begin
         cnt_r <= 16'h0000;
         o_sent <= o_sent + 16'h0001;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule

// ### sim/tb_top.sv
// self-checking bench of the lock detector: registers, hit counting, windows, relock, interrupt
// assumes plld_pkg and plld_edge_model compiled first, plld_defs.svh on the include path
`timescale 1ns/10ps
`include "plld_defs.svh"
module tb_top;
   import plld_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic go = 1'b0;
   logic [15:0] pairs = 16'h0000;
   logic [15:0] offs = 16'h0000;
   logic [15:0] per = 16'h000C;
   logic ref_edge, div_edge, waitreq, lock, relock, irq;
   logic [15:0] sent;
   logic [31:0] rdata;
   plld_avs_req_t avs = '0;
   int err_count = 0;
   int cmp_count = 0;
   int relock_n = 0;
   always #50 clk = ~clk;
   plld_edge_model u_edges (.i_clk(clk), .i_arst_n(arst_n), .i_go(go), .i_pairs(pairs), .i_offset(offs),
      .i_period(per), .o_ref_edge(ref_edge), .o_div_edge(div_edge), .o_sent(sent));
   plld_top DUT (.i_clk(clk), .i_arst_n(arst_n), .i_ref_edge(ref_edge), .i_div_edge(div_edge), .i_avs(avs),
      .o_avs_waitrequest(waitreq), .o_avs_readdata(rdata), .o_lock_detect(lock), .o_relock_req(relock),
      .o_irq(irq));
   always @(posedge clk) begin
      if (relock === 1'b1) relock_n <= relock_n + 1;
   end
   // ----
   // checking and bus tasks
   // ----
   task automatic end_sim();
      $display("mismatches %0d, compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hang();
      err_count++;
      $display("TIMEOUT at %0t", $time);
      end_sim();
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs.address <= a;
      avs.write <= wr;
      avs.read <= !wr;
      avs.writedata <= d;
      avs.byteenable <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      q = rdata;
      avs.write <= 1'b0;
      avs.read <= 1'b0;
      if (waitreq !== 1'b0) hang();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(q, exp);
   endtask
   // sends n ref/div pairs; a period well above the window lets each pair settle before the next
   task automatic run(input int n, input int off, input int period);
      int k;
      k = 0;
      @(posedge clk);
      pairs <= n[15:0];
      offs <= off[15:0];
      per <= period[15:0];
      go <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (sent !== n[15:0] && k < 20000);
      go <= 1'b0;
      if (sent !== n[15:0]) hang();
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [31:0] cfg(input int tgt, input int en, input int dig, input int win, input int rate,
      input int rel);
      plld_cfg_t c;
      c = '0;
      c.lock_hit_count_target = tgt[2:0];
      c.det_enable = en[0];
      c.win_digital = dig[0];
      c.win_code = win[2:0];
      c.timer_rate = rate[1:0];
      c.relock_once = rel[0];
      return {8'h00, c};
   endfunction
   function automatic int target(input int code);
      int t [8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
      return t[code];
   endfunction
   // ----
   // main sequence
   // ----
   initial begin
      int t;
      int c;
      int r;
      int w;
      void'($urandom(89));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      rdchk(`PLLD_ADDR_CFG, 32'h0000014D);
      wr(8'h40, 32'hFFFFFFFF);
      rdchk(8'h40, 32'h00000000);
      wr(`PLLD_ADDR_CFG, 32'hFFFFFFFF);
      rdchk(`PLLD_ADDR_CFG, 32'h00002FCF);
      for (c = 0; c < 4; c++) begin
         wr(`PLLD_ADDR_CFG, cfg(c, 1, 1, 0, 0, 0));
         run(1, 8, 12);
         t = target(c);
         run(t - 1, 0, 12);
         chk(lock, 1'b0);
         rdchk(`PLLD_ADDR_HITS, 32'(t - 1));
         run(1, 0, 12);
         chk(lock, 1'b1);
      end
      wr(`PLLD_ADDR_CFG, cfg(0, 1, 1, 0, 0, 0));
      run(1, 8, 12);
      wr(`PLLD_ADDR_CFG, cfg(0, 1, 1, 0, 0, 1));
      run(5, 0, 12);
      wr(`PLLD_ADDR_IRQ_MASK, 32'h00000000);
      wr(`PLLD_ADDR_IRQ_STAT, 32'h00000007);
      run(1, 8, 12);
      chk(lock, 1'b0);
      rdchk(`PLLD_ADDR_HITS, 32'h00000000);
      chk(relock_n, 1);
      rdchk(`PLLD_ADDR_IRQ_STAT, 32'h00000006);
      chk(irq, 1'b0);
      wr(`PLLD_ADDR_IRQ_MASK, 32'h00000002);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      run(2, 8, 12);
      chk(relock_n, 1);
      wr(`PLLD_ADDR_IRQ_STAT, 32'h00000006);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      run(5, 0, 12);
      chk(lock, 1'b1);
      run(1, 8, 12);
      chk(relock_n, 2);
      wr(`PLLD_ADDR_CFG, cfg(0, 0, 1, 0, 0, 0));
      run(3, 0, 12);
      rdchk(`PLLD_ADDR_HITS, 32'h00000000);
      rdchk(`PLLD_ADDR_STATE, 32'h00000000);
      for (t = 0; t < 6; t++) begin
         c = (t == 0) ? 3 : $urandom % 8;
         r = (t == 0) ? 3 : $urandom % 4;
         if (c + r > 6) c = 6 - r;
         w = 1 << (c + r);
         wr(`PLLD_ADDR_CFG, cfg(7, 1, 1, c, r, 0));
         run(1, w + 2, w + 12);
         rdchk(`PLLD_ADDR_HITS, 32'h00000000);
         run(1, w / 2, w + 12);
         rdchk(`PLLD_ADDR_HITS, 32'h00000001);
      end
      // digital code 7 would take offset 3 in; the one-shot must not
      wr(`PLLD_ADDR_CFG, cfg(7, 1, 0, 7, 0, 0));
      run(1, 3, 12);
      rdchk(`PLLD_ADDR_HITS, 32'h00000000);
      run(1, 0, 12);
      rdchk(`PLLD_ADDR_HITS, 32'h00000001);
      end_sim();
   end
endmodule
